// File: dv/mda_ctrl_sva.sv
/* Assertions on the DRAM controller's strobes, address pins and user port.
 * Bound into mda_ctrl; assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module mda_ctrl_sva #(
	parameter int REF_PERIOD_CYC = mda_pkg::REF_PERIOD_CYC,
	parameter int PWRUP_CYC      = mda_pkg::PWRUP_CYC
) (
	// Clock and reset.
	input wire logic                         clock,
	input wire logic                         rst,
	// User side.
	input wire logic                         req_valid,
	input wire mda_pkg::mda_req_s            req,
	input wire logic                         req_ready,
	input wire logic                         rsp_valid,
	input wire logic                         init_done,
	input wire logic                         auto_refresh_en,
	// DRAM pins.
	input wire logic                         ras_n,
	input wire logic                         cas_n,
	input wire logic                         we_n,
	input wire logic [mda_pkg::MUX_BITS-1:0] multiplexed_address,
	input wire logic                         mem_d
);
	// One refresh slot plus the longest access may pass before a row strobe is due.
	localparam int REF_GAP = REF_PERIOD_CYC / mda_pkg::REF_ROWS + 30;
	logic take;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// A request is taken only when both handshake signals are high.
	assign take = req_valid && req_ready;

	row_setup_a: assert property ($fell(ras_n) |-> $stable(multiplexed_address))
		else $error("row address moved at row strobe");
	col_setup_a: assert property ($fell(cas_n) && !ras_n |-> $stable(multiplexed_address))
		else $error("column address moved at column strobe");
	cbr_order_a: assert property ($fell(cas_n) && ras_n |=> $fell(ras_n))
		else $error("column-first refresh without row strobe");
	rmw_delay_a: assert property ($fell(we_n) && !cas_n |-> $past(!cas_n, 2) && $past(!ras_n, 3))
		else $error("late write enable too early");
	wdata_hold_a: assert property ($fell(cas_n) && !we_n |-> $stable(mem_d))
		else $error("write data moved at column strobe");
	access_time_a: assert property (take && req.op inside {mda_pkg::MDA_OP_READ, mda_pkg::MDA_OP_WRITE}
		|-> ##9 rsp_valid)
		else $error("access answer late or early");
	rmw_time_a: assert property (take && req.op == mda_pkg::MDA_OP_RMW |-> ##10 rsp_valid)
		else $error("rmw answer late or early");
	refresh_quiet_a: assert property (take && req.op >= mda_pkg::MDA_OP_REF_ROW |=> !rsp_valid [*8])
		else $error("refresh gave an answer");
	ready_idle_a: assert property (req_ready |-> init_done && ras_n && cas_n)
		else $error("ready before init or while active");
	refresh_gap_a: assert property (init_done && auto_refresh_en && ras_n
		|-> ##[1:REF_GAP] ($fell(ras_n) || !auto_refresh_en))
		else $error("row strobe gap too long");

	// Main scenarios.
	cover property (take && req.op == mda_pkg::MDA_OP_READ ##9 rsp_valid);
	cover property ($fell(we_n) && !cas_n);
	cover property ($fell(cas_n) && ras_n);
endmodule : mda_ctrl_sva

bind mda_ctrl mda_ctrl_sva #(.REF_PERIOD_CYC(REF_PERIOD_CYC), .PWRUP_CYC(PWRUP_CYC)) u_sva (.clock(clock),
	.rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
	.init_done(init_done), .auto_refresh_en(auto_refresh_en), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
	.multiplexed_address(multiplexed_address), .mem_d(mem_d));
`default_nettype wire

// File: dv/mda_dram_model.sv
/* Behavioural 1M x 1 multiplexed-address DRAM driven by strobe edges.
 * Assumes the controller's strobes are glitch free; unwritten cells read as zero. */
`timescale 1ns/1ps
`default_nettype none
module mda_dram_model (
	// Strobes and address from the controller.
	input wire logic       ras_n,
	input wire logic       cas_n,
	input wire logic       we_n,
	input wire logic [9:0] multiplexed_address,
	input wire logic       mem_d,
	// Data back to the controller.
	output logic           mem_q
);
	bit         mem [int];
	logic [9:0] row_r   = 10'h000;
	logic [9:0] col_r   = 10'h000;
	logic       early_r = 1'b0;
	logic       hold_r  = 1'b0;
	int         ras_cnt = 0;
	int         cbr_cnt = 0;
	// Row strobe restores a whole row: the latched one, or the counter's one when the column strobe led.
	always @(negedge ras_n) begin
		ras_cnt++;
		if (!cas_n) cbr_cnt++;
		else row_r = multiplexed_address;
	end
	// Column strobe freezes the column on the open row; an early write stores here.
	always @(negedge cas_n) begin
		col_r = multiplexed_address;
		early_r = !we_n;
		if (!ras_n && !we_n) mem[{col_r, row_r}] = mem_d;
	end
	// A late write stores on the write-enable edge.
	always @(negedge we_n) if (!ras_n && !cas_n) mem[{col_r, row_r}] = mem_d;
	// Released output shows the inverse of the last bit, so a stale sample cannot pass.
	always @(posedge cas_n) hold_r = ~mem_q;
	always @(ras_n, cas_n, early_r, hold_r, col_r, row_r) begin
		if (!ras_n && !cas_n && !early_r) mem_q = mem.exists({col_r, row_r}) ? mem[{col_r, row_r}] : 1'b0;
		else mem_q = hold_r;
	end
endmodule : mda_dram_model
`default_nettype wire

// File: dv/test_multiplexed_dram_access.sv
/* Self-checking bench for mda_ctrl against the behavioural DRAM model.
 * Assumes shortened refresh and power-up counts; expectations come from a shadow memory. */
`timescale 1ns/1ps
`default_nettype none
module test_multiplexed_dram_access;
	logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, auto_refresh_en = 1'b1;
	logic req_ready, rsp_valid, rsp_data, init_done, ras_n, cas_n, we_n, mem_d, mem_q;
	logic [9:0] multiplexed_address;
	mda_pkg::mda_req_s req = '0;
	int failures = 0, comparisons = 0, n, c0;
	logic [31:0] seed = 32'h59BCD7F0;
	logic [19:0] a;
	bit shadow [int];

	mda_ctrl #(.REF_PERIOD_CYC(5120), .PWRUP_CYC(20)) uut (.clock(clock), .rst(rst), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done(init_done),
		.auto_refresh_en(auto_refresh_en), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.multiplexed_address(multiplexed_address), .mem_d(mem_d), .mem_q(mem_q));
	mda_dram_model dram (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .multiplexed_address(multiplexed_address),
		.mem_d(mem_d), .mem_q(mem_q));

	// 20 MHz clock.
	always #25 clock = ~clock;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	// Unwritten cells are expected to read as zero.
	function automatic logic expect_bit(input logic [19:0] ad);
		return shadow.exists(ad) ? shadow[ad] : 1'b0;
	endfunction : expect_bit

	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		if (failures == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	// Flags that the bench may wait on, picked by number so no reference argument is needed.
	localparam int W_READY = 0;
	localparam int W_RSP   = 1;
	localparam int W_INIT  = 2;

	// Current value of the selected design flag.
	function automatic logic flag_of(input int which);
		return (which == W_READY) ? req_ready : ((which == W_RSP) ? rsp_valid : init_done);
	endfunction : flag_of

	// Bounded wait on a flag; running out counts against the run and ends it.
	task automatic wait_flag(input int which, input int lim);
		n = 0;
		while (flag_of(which) !== 1'b1 && n < lim) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (flag_of(which) !== 1'b1) begin
			failures++;
			tally_and_finish();
		end
	endtask : wait_flag

	// One request; accesses also wait for the answer, and writes and read-modify-writes update the shadow.
	task automatic op(input mda_pkg::mda_op_e o, input logic [19:0] ad, input logic d);
		wait_flag(W_READY, 400);
		req_valid = 1'b1;
		req = '{op: o, addr: ad, wdata: d};
		@(posedge clock);
		#1;
		req_valid = 1'b0;
		if (o <= mda_pkg::MDA_OP_RMW) begin
			wait_flag(W_RSP, 40);
			if (o != mda_pkg::MDA_OP_WRITE) check(rsp_data, expect_bit(ad));
			if (o != mda_pkg::MDA_OP_READ) shadow[ad] = d;
			check(dram.row_r, ad[9:0]);
		end
	endtask : op

	initial begin
		repeat (10) @(posedge clock);
		#1;
		rst = 1'b0;
		wait_flag(W_INIT, 400);
		check(dram.ras_cnt, 8);
		// Address corners, back to back.
		op(mda_pkg::MDA_OP_WRITE, 20'h00000, 1'b1);
		op(mda_pkg::MDA_OP_WRITE, 20'hFFFFF, 1'b1);
		op(mda_pkg::MDA_OP_READ, 20'h00000, 1'b0);
		op(mda_pkg::MDA_OP_RMW, 20'hFFFFF, 1'b0);
		op(mda_pkg::MDA_OP_READ, 20'hFFFFF, 1'b0);
		// Random mix over a small address set so reads hit earlier writes.
		for (int i = 0; i < 40; i++) begin
			seed = xs(seed);
			a = {seed[19:12], 9'h000, seed[2:0]};
			op(mda_pkg::mda_op_e'(seed[25:24] % 3), a, seed[31]);
		end
		// Refresh off from here; a refresh already pending drains first, else it would move the latched row.
		auto_refresh_en = 1'b0;
		repeat (20) @(posedge clock);
		#1;
		// Row-only refresh takes the low nine address bits.
		c0 = dram.cbr_cnt;
		op(mda_pkg::MDA_OP_REF_ROW, 20'hABD55, 1'b0);
		wait_flag(W_READY, 400);
		check(dram.row_r[8:0], 20'h00155);
		// Column-first refresh leaves the latched row alone.
		op(mda_pkg::MDA_OP_REF_CBR, 20'h00000, 1'b0);
		wait_flag(W_READY, 400);
		check(dram.cbr_cnt, c0 + 1);
		check(dram.row_r[8:0], 20'h00155);
		op(mda_pkg::MDA_OP_READ, 20'hFFFFF, 1'b0);
		// Long idle with refresh off reruns the dummy cycles and nothing else.
		c0 = dram.ras_cnt;
		repeat (5400) @(posedge clock);
		#1;
		wait_flag(W_READY, 400);
		check(dram.ras_cnt - c0, 8);
		op(mda_pkg::MDA_OP_READ, 20'h00000, 1'b0);
		tally_and_finish();
	end
endmodule : test_multiplexed_dram_access
`default_nettype wire

// File: rtl/mda_ctrl.sv
/*
 * Host-side controller driving a 1M x 1 multiplexed-address DRAM through its strobe pins.
 * Assumes the DRAM data output returns asynchronously and the user side shares clock.
 */
// Function
// [R1] One row activation refreshes a whole row.
// [R2] Row is low ten bits, column upper ten.
// [R3] Device latches row on row strobe fall.
// [R4] Column latches transparent until column strobe falls.
// [R5] Keep column address valid until data read.
// [R6] Row address, row strobe, column address, column strobe.
// [R7] Read: both strobes low, write enable high.
// [R8] Read data valid until column strobe rises.
// [R9] Write data taken at later falling edge.
// [R10] Write enable before column strobe: early write.
// [R11] Write enable after column strobe: late write.
// [R12] Late enough write enable gives read-modify-write.
// [R13] Refresh all 512 rows within 8 ms.
// [R14] Row-only refresh uses low nine address bits.
// [R15] Column strobe first refreshes internal counter row.
// [R16] Sequential row accesses count as refresh.
// [R17] Fast page: row open, columns cycled.
// [R18] Nibble: strobe cycles step high address bits.
// [R19] Static column: change column without strobe.
// [R20] Static column: chip select may stay low.
// [R21] Dummy row cycles after power-up and long idle.
// [R22] Unmet write timing leaves output undefined.
`timescale 1ns/1ps
`default_nettype none

module mda_ctrl #(
	parameter int REF_PERIOD_CYC = mda_pkg::REF_PERIOD_CYC,
	parameter int PWRUP_CYC      = mda_pkg::PWRUP_CYC
) (
	// Clock and reset.
	input  wire logic                          clock,
	input  wire logic                          rst,
	// User request port.
	input  wire logic                          req_valid,
	input  wire mda_pkg::mda_req_s             req,
	output logic                               req_ready,
	output logic                               rsp_valid,
	output logic                               rsp_data,
	output logic                               init_done,
	input  wire logic                          auto_refresh_en,
	// DRAM pins.
	output logic                               ras_n,
	output logic                               cas_n,
	output logic                               we_n,
	output logic [mda_pkg::MUX_BITS-1:0]       multiplexed_address,
	output logic                               mem_d,
	input  wire logic                          mem_q
);

	localparam int REFI_CYC = REF_PERIOD_CYC / mda_pkg::REF_ROWS;

	// Parameter sanity: counters are 18 bits and read-modify-write timing must hold.
	if (REF_PERIOD_CYC < mda_pkg::REF_ROWS || REF_PERIOD_CYC >= 262144 || PWRUP_CYC < 1 || PWRUP_CYC >= 262144)
		$error("mda_ctrl: counts out of range");
	if (mda_pkg::ACC_CYC < mda_pkg::CWD_CYC || mda_pkg::ACC_CYC + 2 < mda_pkg::RWD_CYC)
		$error("mda_ctrl: access time shorter than write delays");

	mda_pkg::mda_state_e                state_r;
	mda_pkg::mda_op_e                   op_r;
	logic [mda_pkg::ADDR_BITS-1:0]      addr_r;
	logic                               wdata_r;
	logic                               dummy_r;
	logic [17:0]                        cnt_r;
	logic [3:0]                         dummy_left_r;
	logic                               init_pend_r;
	logic [mda_pkg::SYNC_STAGES-1:0]    q_sync_r;
	logic [17:0]                        ref_tmr_r;
	logic                               ref_pend_r;
	logic [mda_pkg::REF_ROW_BITS-1:0]   ref_row_r;
	logic [17:0]                        idle_cnt_r;
	logic                               idle_expire_r;
	logic                               acc_go;
	logic                               ref_go;
	logic                               is_refresh;

	// Start conditions shared by the sequencer and the refresh bookkeeping.
	assign acc_go     = (state_r == mda_pkg::ST_IDLE) && req_valid && req_ready;
	assign ref_go     = (state_r == mda_pkg::ST_IDLE) && !acc_go && !init_pend_r && ref_pend_r;
	assign is_refresh = (op_r == mda_pkg::MDA_OP_REF_ROW) || (op_r == mda_pkg::MDA_OP_REF_CBR);

	// The DRAM output is asynchronous to us, so it passes two flops first.
	always_ff @(posedge clock) begin
		if (rst) begin
			q_sync_r <= '0;
		end else begin
			q_sync_r <= {q_sync_r[0], mem_q};
		end
	end

	// Refresh timer: one row every interval keeps all 512 within the period.
	always_ff @(posedge clock) begin
		if (rst) begin
			ref_tmr_r  <= '0;
			ref_pend_r <= 1'b0;
			ref_row_r  <= '0;
		end else begin
			if (ref_go) begin
				ref_pend_r <= 1'b0;
				ref_row_r  <= ref_row_r + 1'b1; // [R14]
			end
			if (acc_go && req.addr[mda_pkg::REF_ROW_BITS-1:0] == ref_row_r) begin
				ref_row_r <= ref_row_r + 1'b1; // [R16]
				ref_tmr_r <= '0;
			end else if (auto_refresh_en) begin
				if (ref_tmr_r == 18'(REFI_CYC - 1)) begin
					ref_tmr_r  <= '0;
					ref_pend_r <= 1'b1; // [R13] set wins over clear
				end else begin
					ref_tmr_r <= ref_tmr_r + 1'b1;
				end
			end
		end
	end

	// Idle watch: a row strobe cycle restarts it; too long without one demands dummies.
	always_ff @(posedge clock) begin
		if (rst) begin
			idle_cnt_r    <= '0;
			idle_expire_r <= 1'b0;
		end else begin
			idle_expire_r <= 1'b0;
			if (state_r == mda_pkg::ST_ROW || state_r == mda_pkg::ST_CBR || !init_done) begin
				idle_cnt_r <= '0;
			end else if (idle_cnt_r == 18'(REF_PERIOD_CYC - 1)) begin
				idle_cnt_r    <= '0;
				idle_expire_r <= 1'b1; // [R21]
			end else begin
				idle_cnt_r <= idle_cnt_r + 1'b1;
			end
		end
	end

	// Strobe sequencer; all DRAM pins and user outputs are registered here.
	always_ff @(posedge clock) begin
		if (rst) begin
			state_r             <= mda_pkg::ST_PWRUP;
			op_r                <= mda_pkg::MDA_OP_READ;
			addr_r              <= '0;
			wdata_r             <= 1'b0;
			dummy_r             <= 1'b0;
			cnt_r               <= '0;
			dummy_left_r        <= 4'(mda_pkg::DUMMY_CYCLES);
			init_pend_r         <= 1'b1;
			init_done           <= 1'b0;
			req_ready           <= 1'b0;
			rsp_valid           <= 1'b0;
			rsp_data            <= 1'b0;
			ras_n               <= 1'b1;
			cas_n               <= 1'b1;
			we_n                <= 1'b1;
			multiplexed_address <= '0;
			mem_d               <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			cnt_r     <= cnt_r + 1'b1;
			unique case (state_r)
				mda_pkg::ST_PWRUP: begin
					if (cnt_r == 18'(PWRUP_CYC - 1)) begin
						state_r <= mda_pkg::ST_IDLE;
					end
				end
				mda_pkg::ST_IDLE: begin
					cnt_r <= '0;
					if (acc_go) begin
						req_ready           <= 1'b0;
						op_r                <= req.op;
						addr_r              <= req.addr;
						wdata_r             <= req.wdata;
						dummy_r             <= 1'b0;
						multiplexed_address <= req.addr[mda_pkg::MUX_BITS-1:0]; // [R2] [R6]
						if (req.op == mda_pkg::MDA_OP_REF_CBR) begin
							cas_n   <= 1'b0; // [R15]
							state_r <= mda_pkg::ST_CBR;
						end else begin
							state_r <= mda_pkg::ST_ROW;
						end
					end else if (init_pend_r || ref_pend_r) begin
						req_ready           <= 1'b0;
						op_r                <= mda_pkg::MDA_OP_REF_ROW;
						dummy_r             <= init_pend_r;
						multiplexed_address <= {1'b0, ref_row_r}; // [R14]
						state_r             <= mda_pkg::ST_ROW;
					end else begin
						req_ready <= 1'b1;
					end
				end
				mda_pkg::ST_CBR: begin
					ras_n   <= 1'b0; // [R15] column strobe already low
					cnt_r   <= '0;
					state_r <= mda_pkg::ST_RAS;
				end
				mda_pkg::ST_ROW: begin
					ras_n   <= 1'b0; // [R3] [R6] row address stood one cycle
					cnt_r   <= '0;
					state_r <= mda_pkg::ST_RAS;
				end
				mda_pkg::ST_RAS: begin
					if (is_refresh) begin
						// Column strobe stays high for row-only refresh; whole row restored.
						if (cnt_r == 18'(mda_pkg::RAS_CYC - 1)) begin
							cnt_r   <= '0;
							state_r <= mda_pkg::ST_PRE; // [R1] [R14]
						end
					end else begin
						multiplexed_address <= addr_r[mda_pkg::ADDR_BITS-1:mda_pkg::MUX_BITS]; // [R2] [R6]
						if (op_r == mda_pkg::MDA_OP_WRITE) begin
							we_n  <= 1'b0; // [R10] early write, data taken at column strobe
							mem_d <= wdata_r; // [R9]
						end
						state_r <= mda_pkg::ST_COL;
					end
				end
				mda_pkg::ST_COL: begin
					cas_n   <= 1'b0; // [R6] [R7] column address stood one cycle
					cnt_r   <= '0;
					state_r <= mda_pkg::ST_CAS;
				end
				mda_pkg::ST_CAS: begin
					// Wait for access plus the two sync stages; address held for the read.
					if (cnt_r == 18'(mda_pkg::ACC_CYC + mda_pkg::SYNC_STAGES)) begin
						cnt_r <= '0;
						if (op_r != mda_pkg::MDA_OP_WRITE) begin
							rsp_data <= q_sync_r[mda_pkg::SYNC_STAGES-1]; // [R5] [R8]
						end
						if (op_r == mda_pkg::MDA_OP_RMW) begin
							we_n    <= 1'b0; // [R11] [R12] late enough after both strobes
							mem_d   <= wdata_r; // [R9]
							state_r <= mda_pkg::ST_WE;
						end else begin
							rsp_valid <= 1'b1;
							state_r   <= mda_pkg::ST_PRE;
						end
					end
				end
				mda_pkg::ST_WE: begin
					if (cnt_r == 18'(mda_pkg::WP_CYC - 1)) begin
						cnt_r     <= '0;
						rsp_valid <= 1'b1;
						state_r   <= mda_pkg::ST_PRE;
					end
				end
				mda_pkg::ST_PRE: begin
					ras_n <= 1'b1;
					cas_n <= 1'b1;
					we_n  <= 1'b1;
					if (cnt_r == 18'(mda_pkg::RP_CYC - 1)) begin
						cnt_r   <= '0;
						state_r <= mda_pkg::ST_IDLE;
						if (dummy_r) begin
							dummy_left_r <= dummy_left_r - 1'b1; // [R21]
							if (dummy_left_r == 4'h1) begin
								init_pend_r <= 1'b0;
								init_done   <= 1'b1;
							end
						end
					end
				end
			endcase
			// A long idle re-arms the dummy cycles; placed last so it wins.
			if (idle_expire_r) begin
				init_pend_r  <= 1'b1; // [R21]
				init_done    <= 1'b0;
				dummy_left_r <= 4'(mda_pkg::DUMMY_CYCLES);
				req_ready    <= 1'b0;
			end
		end
	end

endmodule : mda_ctrl

`default_nettype wire

// File: rtl/mda_pkg.sv
/*
 * Shared constants and types for the multiplexed DRAM access controller.
 * Assumes a 20 MHz system clock and a 1M x 1 DRAM with separate data in and out pins.
 */
package mda_pkg;

	// Clock rate and address geometry.
	localparam int CLK_MHZ       = 20;
	localparam int ADDR_BITS     = 20;
	localparam int MUX_BITS      = 10;
	localparam int REF_ROW_BITS  = 9;
	localparam int REF_ROWS      = 512;
	localparam int ROW_CELLS     = 2048;
	localparam int SYNC_STAGES   = 2;

	// Times in their own units; strobe figures are plain defaults, tune per part.
	localparam int T_PWRUP_US    = 100;
	localparam int DUMMY_CYCLES  = 8;
	localparam int T_REF_MS      = 8;
	localparam int T_RP_NS       = 100;
	localparam int T_RAS_NS      = 120;
	localparam int T_ACC_NS      = 100;
	localparam int T_CWD_NS      = 60;
	localparam int T_RWD_NS      = 150;
	localparam int T_WP_NS       = 40;

	// Least time in nanoseconds to whole cycles, rounded up, never below one.
	function automatic int mda_ns2cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : mda_ns2cyc

	// Derived cycle counts.
	localparam int PWRUP_CYC     = T_PWRUP_US * CLK_MHZ;
	localparam int REF_PERIOD_CYC = T_REF_MS * 1000 * CLK_MHZ;
	localparam int RP_CYC        = mda_ns2cyc(T_RP_NS);
	localparam int RAS_CYC       = mda_ns2cyc(T_RAS_NS);
	localparam int ACC_CYC       = mda_ns2cyc(T_ACC_NS);
	localparam int CWD_CYC       = mda_ns2cyc(T_CWD_NS);
	localparam int RWD_CYC       = mda_ns2cyc(T_RWD_NS);
	localparam int WP_CYC        = mda_ns2cyc(T_WP_NS);

	// User commands.
	typedef enum logic [2:0] {
		MDA_OP_READ    = 3'h0,
		MDA_OP_WRITE   = 3'h1,
		MDA_OP_RMW     = 3'h2,
		MDA_OP_REF_ROW = 3'h3,
		MDA_OP_REF_CBR = 3'h4
	} mda_op_e;

	// Controller states, one-hot.
	typedef enum logic [8:0] {
		ST_PWRUP = 9'h001,
		ST_IDLE  = 9'h002,
		ST_ROW   = 9'h004,
		ST_RAS   = 9'h008,
		ST_COL   = 9'h010,
		ST_CAS   = 9'h020,
		ST_WE    = 9'h040,
		ST_CBR   = 9'h080,
		ST_PRE   = 9'h100
	} mda_state_e;

	// A user request.
	typedef struct packed {
		mda_op_e               op;
		logic [ADDR_BITS-1:0]  addr;
		logic                  wdata;
	} mda_req_s;

endpackage : mda_pkg
